/* File: rtl/dtc_edge.sv */
// Edge detector for a pin already synchronous to pclk
`timescale 1ns/100ps
module dtc_edge
    import dtc_pkg::*;
(
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic pin,      // Sampled pin level
    output logic      fall,     // High-to-low pulse
    output logic      rise      // Low-to-high pulse
);
    dtc_edge_s q;
    dtc_edge_s d;

    always_comb begin
        d      = q;
        d.prev = pin;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{prev: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign fall = q.prev & ~pin;
    assign rise = ~q.prev & pin;
endmodule // dtc_edge

/* File: rtl/dtc_map.svh */
// Register indices, field positions, reset values and prescale counts of the timer pair
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// -----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// -----------------------------------------------------------------------------
`define DTC_IDX_CTRL    8'h88
`define DTC_IDX_MODE    8'h89
`define DTC_IDX_T0_LOW  8'h8A
`define DTC_IDX_T1_LOW  8'h8B
`define DTC_IDX_T0_HIGH 8'h8C
`define DTC_IDX_T1_HIGH 8'h8D
`define DTC_IDX_CLKCTL  8'h8E
`define DTC_IDX_IRQCFG  8'h8F
`define DTC_IDX_ISTAT   8'h90
`define DTC_IDX_IMASK   8'h91
`define DTC_ADDR_W      12

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define DTC_MODE_TIMER_ONE_GATE_ENABLE  7
`define DTC_MODE_CT1    6
`define DTC_MODE_M1     5:4
`define DTC_MODE_TIMER_ZERO_GATE_ENABLE  3
`define DTC_MODE_CT0    2
`define DTC_MODE_M0     1:0
`define DTC_CTRL_TF1    7
`define DTC_CTRL_TR1    6
`define DTC_CTRL_TF0    5
`define DTC_CTRL_TR0    4
`define DTC_CTRL_XINT   3:0
`define DTC_CLK_T1SYS   3
`define DTC_CLK_T0SYS   2
`define DTC_CLK_SCA     1:0
`define DTC_CFG_POL1    1
`define DTC_CFG_POL0    0

// -----------------------------------------------------------------------------
// Reset values and prescale counts
// -----------------------------------------------------------------------------
`define DTC_RST_BYTE    8'h00
`define DTC_DIV12_LAST  4'hB
`define DTC_DIV48_LAST  6'h2F
`define DTC_DIV4_LAST   2'h3
`define DTC_EXT8_LAST   3'h7

`endif

/* File: rtl/dtc_pkg.sv */
// Types shared by the timer pair modules
package dtc_pkg;
`include "dtc_map.svh"

    // Timer operating modes in field order
    typedef enum logic [1:0] {
        DTC_M13,
        DTC_M16,
        DTC_M8RL,
        DTC_MSPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic       tf1;
        logic       tr1;
        logic       tf0;
        logic       tr0;
        logic [3:0] xint;
        logic       t1sys;
        logic       t0sys;
        logic [1:0] tick_divider_select;
        logic       pol1;
        logic       pol0;
        logic [1:0] ist;
        logic [1:0] imask;
        logic [3:0] c12;
        logic [5:0] c48;
        logic [2:0] c8;
    } dtc_state_s;

    typedef struct packed {
        logic prev;
    } dtc_edge_s;

endpackage

/* File: rtl/dtc_top.sv */
// Dual counter/timer with shared mode register and APB register access
`timescale 1ns/100ps
`include "dtc_map.svh"
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic                    pclk,          // System clock, 100 MHz
    input  wire logic                    presetn,       // Async reset, active low
    input  wire logic                    psel,          // APB select
    input  wire logic                    penable,       // APB access phase
    input  wire logic                    pwrite,        // APB write
    input  wire logic [`DTC_ADDR_W-1:0]  paddr,         // APB byte address
    input  wire logic [31:0]             pwdata,        // APB write data
    output logic      [31:0]             prdata,        // APB read data
    output logic                         pready,        // APB ready
    output logic                         pslverr,       // APB error, unmapped
    input  wire logic                    count_pin_zero,   // Count input zero
    input  wire logic                    count_pin_one,    // Count input one
    input  wire logic                    ext_irq_zero_line,// Gate line zero
    input  wire logic                    ext_irq_one_line, // Gate line one
    input  wire logic                    ext_clk,       // External prescale clock
    input  wire logic                    vector_ack_zero,  // CPU vectored to timer zero
    input  wire logic                    vector_ack_one,   // CPU vectored to timer one
    output logic                         timer_zero_overflow_flag, // Flag zero
    output logic                         timer_one_overflow_flag,  // Flag one
    output logic                         irq            // Interrupt, active high
);
    dtc_state_s q;
    dtc_state_s d;

    logic       pin0_fall;
    logic       pin1_fall;
    logic       ext_rise;
    logic       tick4;
    logic       tick12;
    logic       tick48;
    logic       tick_ext;
    logic       presc_tick;
    logic       clk0_src;
    logic       clk1_src;
    logic       tick0;
    logic       tick1;
    logic       act0;
    logic       act1;
    logic       en0;
    logic       en1;
    logic       hi_run;
    logic       ovf0;
    logic       ovf1;
    logic       acc;
    logic       wr;
    logic       hit;
    logic       page_ok;
    logic [7:0] idx;
    logic [7:0] rbyte;
    dtc_mode_e  m0;
    dtc_mode_e  m1;

    dtc_edge u_pin0 (.pclk(pclk), .presetn(presetn), .pin(count_pin_zero), .fall(pin0_fall), .rise());
    dtc_edge u_pin1 (.pclk(pclk), .presetn(presetn), .pin(count_pin_one), .fall(pin1_fall), .rise());
    dtc_edge u_ext  (.pclk(pclk), .presetn(presetn), .pin(ext_clk), .fall(), .rise(ext_rise));

    // -------------------------------------------------------------------------
    // Tick selection and gating
    // -------------------------------------------------------------------------
    assign m0       = dtc_mode_e'(q.mode[`DTC_MODE_M0]);
    assign m1       = dtc_mode_e'(q.mode[`DTC_MODE_M1]);
    assign tick4    = (q.c48[1:0] == `DTC_DIV4_LAST);
    assign tick12   = (q.c12 == `DTC_DIV12_LAST);
    assign tick48   = (q.c48 == `DTC_DIV48_LAST);
    assign tick_ext = ext_rise & (q.c8 == `DTC_EXT8_LAST);

    always_comb begin
        case (q.tick_divider_select)
            2'h0:    presc_tick = tick12;
            2'h1:    presc_tick = tick4;
            2'h2:    presc_tick = tick48;
            default: presc_tick = tick_ext;
        endcase
    end

    assign clk0_src = q.t0sys | presc_tick;
    assign clk1_src = q.t1sys | presc_tick;
    assign tick0    = q.mode[`DTC_MODE_CT0] ? pin0_fall : clk0_src;
    assign tick1    = q.mode[`DTC_MODE_CT1] ? pin1_fall : clk1_src;
    assign act0     = q.pol0 ? ext_irq_zero_line : ~ext_irq_zero_line;
    assign act1     = q.pol1 ? ext_irq_one_line : ~ext_irq_one_line;
    assign en0      = q.tr0 & (~q.mode[`DTC_MODE_TIMER_ZERO_GATE_ENABLE] | act0);
    assign en1      = q.tr1 & (~q.mode[`DTC_MODE_TIMER_ONE_GATE_ENABLE] | act1) & (m1 != DTC_MSPLIT);
    assign hi_run   = (m0 == DTC_MSPLIT) & q.tr1 & clk0_src;

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    assign acc    = psel & penable;
    // Index bits above the byte field must be zero, else the access is unmapped
    assign page_ok = (paddr[`DTC_ADDR_W-1:`DTC_ADDR_W-2] == 2'h0);
    assign wr      = acc & pwrite & page_ok;
    assign idx     = paddr[`DTC_ADDR_W-3:2];
    assign pready  = 1'b1;

    always_comb begin
        hit = page_ok;
        case (idx)
            `DTC_IDX_CTRL:    rbyte = {q.tf1, q.tr1, q.tf0, q.tr0, q.xint};
            `DTC_IDX_MODE:    rbyte = q.mode;
            `DTC_IDX_T0_LOW:  rbyte = q.tl0;
            `DTC_IDX_T1_LOW:  rbyte = q.tl1;
            `DTC_IDX_T0_HIGH: rbyte = q.th0;
            `DTC_IDX_T1_HIGH: rbyte = q.th1;
            `DTC_IDX_CLKCTL:  rbyte = {4'h0, q.t1sys, q.t0sys, q.tick_divider_select};
            `DTC_IDX_IRQCFG:  rbyte = {6'h00, q.pol1, q.pol0};
            `DTC_IDX_ISTAT:   rbyte = {6'h00, q.ist};
            `DTC_IDX_IMASK:   rbyte = {6'h00, q.imask};
            default: begin
                rbyte = 8'h00;
                hit   = 1'b0;
            end
        endcase
    end

    assign prdata  = {24'h000000, rbyte};
    assign pslverr = acc & ~hit;

    // -------------------------------------------------------------------------
    // Count step: {overflow, high, low}
    // -------------------------------------------------------------------------
    function automatic logic [16:0] dtc_step(input dtc_mode_e m, input logic [7:0] hi, input logic [7:0] lo);
        logic [12:0] n13;
        logic [15:0] n16;
        n13 = {hi, lo[4:0]} + 13'h0001;
        n16 = {hi, lo} + 16'h0001;
        case (m)
            DTC_M13:  dtc_step = {&{hi, lo[4:0]}, n13[12:5], lo[7:5], n13[4:0]};
            DTC_M16:  dtc_step = {&{hi, lo}, n16};
            DTC_M8RL: dtc_step = {&lo, hi, ((&lo) ? hi : n16[7:0])};
            default:  dtc_step = {&lo, hi, n16[7:0]};
        endcase
    endfunction

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        logic [16:0] s0;
        logic [16:0] s1;
        s0    = dtc_step(m0, q.th0, q.tl0);
        s1    = dtc_step(m1, q.th1, q.tl1);
        d     = q;
        ovf0  = 1'b0;
        ovf1  = 1'b0;
        d.c12 = tick12 ? 4'h0 : q.c12 + 4'h1;
        d.c48 = tick48 ? 6'h00 : q.c48 + 6'h01;
        if (ext_rise) begin
            d.c8 = q.c8 + 3'h1;
        end
        if (en0 && tick0) begin
            d.th0 = (m0 == DTC_MSPLIT) ? q.th0 : s0[15:8];
            d.tl0 = s0[7:0];
            ovf0  = s0[16];
        end
        if (hi_run) begin
            d.th0 = q.th0 + 8'h01;
            ovf1  = &q.th0;
        end
        if (en1 && tick1) begin
            d.th1 = s1[15:8];
            d.tl1 = s1[7:0];
            ovf1  = ovf1 | (s1[16] & (m0 != DTC_MSPLIT));
        end
        if (wr) begin
            case (idx)
                `DTC_IDX_CTRL: begin
                    d.tf1  = pwdata[`DTC_CTRL_TF1];
                    d.tr1  = pwdata[`DTC_CTRL_TR1];
                    d.tf0  = pwdata[`DTC_CTRL_TF0];
                    d.tr0  = pwdata[`DTC_CTRL_TR0];
                    d.xint = pwdata[`DTC_CTRL_XINT];
                end
                `DTC_IDX_MODE:    d.mode = pwdata[7:0];
                `DTC_IDX_T0_LOW:  d.tl0 = pwdata[7:0];
                `DTC_IDX_T1_LOW:  d.tl1 = pwdata[7:0];
                `DTC_IDX_T0_HIGH: d.th0 = pwdata[7:0];
                `DTC_IDX_T1_HIGH: d.th1 = pwdata[7:0];
                `DTC_IDX_CLKCTL: begin
                    d.t1sys = pwdata[`DTC_CLK_T1SYS];
                    d.t0sys = pwdata[`DTC_CLK_T0SYS];
                    d.tick_divider_select   = pwdata[`DTC_CLK_SCA];
                end
                `DTC_IDX_IRQCFG: begin
                    d.pol1 = pwdata[`DTC_CFG_POL1];
                    d.pol0 = pwdata[`DTC_CFG_POL0];
                end
                `DTC_IDX_ISTAT:   d.ist = q.ist & ~pwdata[1:0];
                `DTC_IDX_IMASK:   d.imask = pwdata[1:0];
                default: ;
            endcase
        end
        // Acknowledge clears, hardware set wins over any clear
        if (vector_ack_zero) begin
            d.tf0 = 1'b0;
        end
        if (vector_ack_one) begin
            d.tf1 = 1'b0;
        end
        d.tf0 = d.tf0 | ovf0;
        d.tf1 = d.tf1 | ovf1;
        d.ist = d.ist | {ovf1, ovf0};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign timer_zero_overflow_flag = q.tf0;
    assign timer_one_overflow_flag  = q.tf1;
    assign irq                      = |(q.ist & q.imask);

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rl_wrap;
        (m0 == DTC_M8RL) && en0 && tick0 && (q.tl0 == 8'hFF) && !wr;
    endsequence

    sequence s_rl_done;
        (q.tl0 == $past(q.th0)) && q.tf0 && (q.th0 == $past(q.th0));
    endsequence

    chk_gate_zero_stop: assert property (
        (q.mode[`DTC_MODE_TIMER_ZERO_GATE_ENABLE] && !act0 && m0 != DTC_MSPLIT && !wr) |=> $stable({q.th0, q.tl0}))
        else $error("timer zero counted while gated off");

    chk_gate_one_stop: assert property (
        (q.mode[`DTC_MODE_TIMER_ONE_GATE_ENABLE] && !act1 && !wr) |=> $stable({q.th1, q.tl1}))
        else $error("timer one counted while gated off");

    chk_one_mode3_hold: assert property (
        (m1 == DTC_MSPLIT && !wr) |=> $stable({q.th1, q.tl1}))
        else $error("timer one moved while inactive");

    chk_pin_zero_count: assert property (
        (q.mode[`DTC_MODE_CT0] && en0 && pin0_fall && m0 == DTC_M16 && !wr && {q.th0, q.tl0} != 16'hFFFF)
        |=> ({q.th0, q.tl0} == $past({q.th0, q.tl0}) + 16'h0001))
        else $error("timer zero missed a pin edge");

    chk_sys_one_count: assert property (
        (!q.mode[`DTC_MODE_CT1] && q.t1sys && en1 && m1 == DTC_M16 && !wr && {q.th1, q.tl1} != 16'hFFFF)
        |=> ({q.th1, q.tl1} == $past({q.th1, q.tl1}) + 16'h0001))
        else $error("timer one did not count system clock");

    chk_reload_low: assert property (s_rl_wrap |=> s_rl_done)
        else $error("low byte not reloaded from high byte");

    chk_wrap_13bit: assert property (
        (m1 == DTC_M13 && m0 != DTC_MSPLIT && en1 && tick1 && q.th1 == 8'hFF && q.tl1[4:0] == 5'h1F && !wr)
        |=> (q.tf1 && q.th1 == 8'h00 && q.tl1[4:0] == 5'h00))
        else $error("13-bit wrap did not set flag");

    chk_presc_48: assert property (
        (q.tick_divider_select == 2'h2 && presc_tick) |-> (q.c48 == 6'h2F) ##1 (!tick48) [*8])
        else $error("divide by 48 tick misplaced");

    chk_ack_clear: assert property (
        (vector_ack_zero && !ovf0) |=> !q.tf0)
        else $error("acknowledge did not clear flag zero");

    chk_run_off: assert property (
        (!q.tr0 && m0 != DTC_MSPLIT && !wr) |=> $stable({q.th0, q.tl0}))
        else $error("timer zero ran with run bit clear");

    chk_split_high: assert property (
        (m0 == DTC_MSPLIT && q.tr1 && clk0_src && q.th0 != 8'hFF && !wr)
        |=> (q.th0 == $past(q.th0) + 8'h01))
        else $error("split high byte did not count");

    chk_reg_hold: assert property (
        (wr && idx == `DTC_IDX_T1_HIGH && m1 == DTC_MSPLIT) |=> (q.th1 == $past(pwdata[7:0])))
        else $error("timer one high byte write lost");
endmodule // dtc_top

/* File: tb/dtc_pins.sv */
// Far-side model: count pins, gate lines and external prescale clock
`timescale 1ns/100ps
module dtc_pins (
    input  wire logic       pclk,              // System clock
    input  wire logic       presetn,           // Async reset, active low
    input  wire logic [1:0] fall_req,          // One-cycle pulse request per pin
    input  wire logic [1:0] gate_lvl,          // Requested gate line levels
    input  wire logic       ext_on,            // Run the external clock
    output logic            count_pin_zero,    // Count input zero
    output logic            count_pin_one,     // Count input one
    output logic            ext_irq_zero_line, // Gate line zero
    output logic            ext_irq_one_line,  // Gate line one
    output logic            ext_clk            // External prescale clock
);
    logic [1:0] low0_q;
    logic [1:0] low1_q;
    logic       xclk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low0_q <= 2'h0;
            low1_q <= 2'h0;
            xclk_q <= 1'b0;
        end else begin
            low0_q <= fall_req[0] ? 2'h2 : low0_q - {1'b0, |low0_q};
            low1_q <= fall_req[1] ? 2'h2 : low1_q - {1'b0, |low1_q};
            xclk_q <= ext_on ? ~xclk_q : xclk_q;
        end
    end
    // Pins idle high, low for two cycles per request
    assign count_pin_zero    = (low0_q == 2'h0);
    assign count_pin_one     = (low1_q == 2'h0);
    assign ext_irq_zero_line = gate_lvl[0];
    assign ext_irq_one_line  = gate_lvl[1];
    assign ext_clk           = xclk_q;
endmodule // dtc_pins

/* File: tb/tb_dtc_top.sv */
// Self-checking bench of the timer pair
`timescale 1ns/100ps
`include "dtc_map.svh"
module tb_dtc_top;
    import dtc_pkg::*;
    typedef struct {
        logic t; logic [7:0] mode; logic [7:0] lo; logic [7:0] hi; int n;
        logic [7:0] elo; logic [7:0] ehi; logic ef;
    } dtc_row_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cp0, cp1, gl0, gl1, xclk, tf0, tf1, irq;
    logic        vack0 = 1'b0;
    logic        vack1 = 1'b0;
    logic [1:0]  fall_req = 2'h0;
    logic [1:0]  gate_lvl = 2'h3;
    logic [31:0] rd_data;
    logic        last_err;
    logic [7:0]  lo_idx, hi_idx, a;
    int          fail_count = 0;
    int          compares = 0;
    dtc_row_s    r;
    dtc_row_s rows [8] = '{
        '{1'b0, 8'h04, 8'hFF, 8'hFF, 1, 8'hE0, 8'h00, 1'b1},
        '{1'b0, 8'h05, 8'hFE, 8'h12, 2, 8'h00, 8'h13, 1'b0},
        '{1'b0, 8'h06, 8'hFF, 8'hA5, 1, 8'hA5, 8'hA5, 1'b1},
        '{1'b0, 8'h07, 8'hFF, 8'h00, 1, 8'h00, 8'h00, 1'b1},
        '{1'b1, 8'h44, 8'hFF, 8'hFF, 1, 8'hE0, 8'h00, 1'b1},
        '{1'b1, 8'h54, 8'hFE, 8'h12, 2, 8'h00, 8'h13, 1'b0},
        '{1'b1, 8'h64, 8'hFF, 8'h5A, 1, 8'h5A, 8'h5A, 1'b1},
        '{1'b1, 8'h74, 8'h3C, 8'hC3, 1, 8'h3C, 8'hC3, 1'b0}
    };
    logic [7:0] div_exp [5] = '{8'h04, 8'h0C, 8'h01, 8'h03, 8'h30};

    always #5 pclk = ~pclk;

    dtc_pins pins_u (.pclk(pclk), .presetn(presetn), .fall_req(fall_req), .gate_lvl(gate_lvl),
        .ext_on(1'b1), .count_pin_zero(cp0), .count_pin_one(cp1), .ext_irq_zero_line(gl0),
        .ext_irq_one_line(gl1), .ext_clk(xclk));
    dtc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin_zero(cp0), .count_pin_one(cp1), .ext_irq_zero_line(gl0), .ext_irq_one_line(gl1),
        .ext_clk(xclk), .vector_ack_zero(vack0), .vector_ack_one(vack1),
        .timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1), .irq(irq));

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse(input logic [1:0] which, input int n);
        repeat (n) begin
            fall_req <= which;
            @(posedge pclk);
            fall_req <= 2'h0;
            repeat (6) @(posedge pclk);
        end
    endtask

    task automatic reset_dut();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        final_report();
    end

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            r = rows[i];
            lo_idx = r.t ? `DTC_IDX_T1_LOW : `DTC_IDX_T0_LOW;
            hi_idx = r.t ? `DTC_IDX_T1_HIGH : `DTC_IDX_T0_HIGH;
            reset_dut();
            apb(`DTC_IDX_MODE, 1'b1, r.mode);
            apb(lo_idx, 1'b1, r.lo);
            apb(hi_idx, 1'b1, r.hi);
            apb(`DTC_IDX_CTRL, 1'b1, r.t ? 8'h40 : 8'h10);
            pulse(r.t ? 2'h2 : 2'h1, r.n);
            apb(lo_idx, 1'b0, 8'h00);
            check(rd_data, {24'h0, r.elo});
            apb(hi_idx, 1'b0, 8'h00);
            check(rd_data, {24'h0, r.ehi});
            check({31'h0, r.t ? tf1 : tf0}, {31'h0, r.ef});
            apb(`DTC_IDX_MODE, 1'b0, 8'h00);
            check(rd_data, {24'h0, r.mode});
        end
        reset_dut();
        foreach (rows[i]) begin
            a = 8'h89 + 8'(i % 5);
            apb(a, 1'b0, 8'h00);
            check(rd_data, 32'h0000_0000);
        end
        apb(8'h92, 1'b1, 8'h5A);
        check({31'h0, last_err}, 32'h0000_0001);
        // Gate follows the line at its configured polarity
        apb(`DTC_IDX_IRQCFG, 1'b1, 8'h03);
        apb(`DTC_IDX_MODE, 1'b1, 8'hDD);
        apb(`DTC_IDX_CTRL, 1'b1, 8'h50);
        gate_lvl <= 2'h0;
        pulse(2'h3, 1);
        gate_lvl <= 2'h3;
        pulse(2'h3, 1);
        apb(`DTC_IDX_T0_LOW, 1'b0, 8'h00);
        check(rd_data, 32'h0000_0001);
        apb(`DTC_IDX_T1_LOW, 1'b0, 8'h00);
        check(rd_data, 32'h0000_0001);
        // Prescale ticks and system clock over 48 cycles
        for (int s = 0; s < 5; s++) begin
            reset_dut();
            apb(`DTC_IDX_CLKCTL, 1'b1, s < 4 ? 8'(s) : 8'h04);
            apb(`DTC_IDX_MODE, 1'b1, 8'h01);
            apb(`DTC_IDX_CTRL, 1'b1, 8'h10);
            apb(`DTC_IDX_T0_LOW, 1'b0, 8'h00);
            a = rd_data[7:0];
            repeat (45) @(posedge pclk);
            apb(`DTC_IDX_T0_LOW, 1'b0, 8'h00);
            check({24'h0, rd_data[7:0] - a}, {24'h0, div_exp[s]});
        end
        // Split high byte on run one, timer one on system clock
        reset_dut();
        apb(`DTC_IDX_CLKCTL, 1'b1, 8'h0C);
        apb(`DTC_IDX_MODE, 1'b1, 8'h13);
        apb(`DTC_IDX_T0_HIGH, 1'b1, 8'hE0);
        apb(`DTC_IDX_CTRL, 1'b1, 8'h40);
        apb(`DTC_IDX_T0_HIGH, 1'b0, 8'h00);
        a = rd_data[7:0];
        repeat (45) @(posedge pclk);
        apb(`DTC_IDX_T0_HIGH, 1'b0, 8'h00);
        check({24'h0, rd_data[7:0] - a}, 32'h0000_0030);
        apb(`DTC_IDX_T1_LOW, 1'b0, 8'h00);
        check(rd_data, 32'h0000_0035);
        apb(`DTC_IDX_T0_LOW, 1'b0, 8'h00);
        check(rd_data, 32'h0000_0000);
        check({30'h0, tf1, tf0}, 32'h0000_0002);
        // Overflow flags, status, mask and vector acknowledge
        reset_dut();
        apb(`DTC_IDX_MODE, 1'b1, 8'h55);
        apb(`DTC_IDX_T0_LOW, 1'b1, 8'hFF);
        apb(`DTC_IDX_T0_HIGH, 1'b1, 8'hFF);
        apb(`DTC_IDX_T1_LOW, 1'b1, 8'hFF);
        apb(`DTC_IDX_T1_HIGH, 1'b1, 8'hFF);
        apb(`DTC_IDX_CTRL, 1'b1, 8'h50);
        pulse(2'h3, 1);
        check({31'h0, irq}, 32'h0000_0000);
        apb(`DTC_IDX_IMASK, 1'b1, 8'h01);
        check({29'h0, tf1, tf0, irq}, 32'h0000_0007);
        vack0 <= 1'b1;
        vack1 <= 1'b1;
        @(posedge pclk);
        vack0 <= 1'b0;
        vack1 <= 1'b0;
        @(posedge pclk);
        check({29'h0, tf1, tf0, irq}, 32'h0000_0001);
        apb(`DTC_IDX_ISTAT, 1'b1, 8'h01);
        check({31'h0, irq}, 32'h0000_0000);
        // Mid-run reset drops pending status and restores idle outputs
        reset_dut();
        check({28'h0, pready, tf1, tf0, irq}, 32'h0000_0008);
        apb(`DTC_IDX_ISTAT, 1'b0, 8'h00);
        check(rd_data, 32'h0000_0000);
        final_report();
    end
endmodule // tb_dtc_top
